// file: rtl/bms_pkg.sv
// constants for the battery monitor and supervisor timing block
// assumes comparator outputs as logic levels, one 125 MHz clock
package bms_pkg;
	localparam longint unsigned CLK_HZ = 64'd125_000_000;
	localparam longint unsigned FLAG_TIMEOUT_MS = 64'd150;
	localparam longint unsigned SUPPLY_SHORT_MS = 64'd150;
	localparam longint unsigned SUPPLY_LONG_MS = 64'd1200;
	localparam longint unsigned MANUAL_PULSE_MS = 64'd150;
	localparam longint unsigned DEBOUNCE_MS = 64'd150;
	localparam longint unsigned MS_PER_S = 64'd1000;
	// least times round up to whole cycles
	localparam longint unsigned FLAG_TIMEOUT_CYC =
		(FLAG_TIMEOUT_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
	localparam longint unsigned SUPPLY_SHORT_CYC =
		(SUPPLY_SHORT_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
	localparam longint unsigned SUPPLY_LONG_CYC =
		(SUPPLY_LONG_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
	localparam longint unsigned MANUAL_PULSE_CYC =
		(MANUAL_PULSE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
	localparam longint unsigned DEBOUNCE_CYC =
		(DEBOUNCE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
	localparam int TMR_W = 32;
	// synchroniser lanes
	localparam int SYNC_N = 4;
	localparam int IDX_LOW = 0;
	localparam int IDX_HIGH = 1;
	localparam int IDX_SUPPLY = 2;
	localparam int IDX_MANUAL = 3;
	// manual lane resets to its idle high level: a low value here
	// would read as a press and fire a pulse right after reset
	localparam logic [SYNC_N-1:0] SYNC_RST = 4'h8;
	localparam logic FLAG_IDLE_N = 1'b1;
	typedef enum logic {MR_ARMED, MR_HELD} bms_mr_e;
endpackage

// file: rtl/bms_tmr_if.sv
// carrier between the timing logic and one timeout counter
// run is a level from the owner; done is the counter's answer
`timescale 1ns/10ps
interface bms_tmr_if;
	logic run;
	logic done;
	modport owner
	(
		output run,
		input done
	);
	modport timer
	(
		input run,
		output done
	);
endinterface

// file: rtl/bms_timer.sv
// timeout counter: counts cycles while run holds, clears when it drops
// assumes run comes from logic on the same clock
`timescale 1ns/10ps
module bms_timer
	import bms_pkg::*;
#(
	parameter longint unsigned CYC = bms_pkg::FLAG_TIMEOUT_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	bms_tmr_if.timer tif
);
	localparam logic [TMR_W-1:0] LIMIT = CYC[TMR_W-1:0];
	logic [TMR_W-1:0] cnt_r;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_r <= '0;
		else if (!tif.run)
			cnt_r <= '0;
		else if (cnt_r != LIMIT)
			cnt_r <= cnt_r + 1'b1;
	end

	// done stays up while run holds past the limit
	assign tif.done = tif.run && (cnt_r == LIMIT);
endmodule

// file: rtl/bms_top.sv
// battery flag and processor reset timing, one clock
// assumes comparator levels are high when above trip and are asynchronous
`timescale 1ns/10ps
module bms_top
#(
	parameter bit DUAL_OUTPUT = 1'b1,
	parameter bit LONG_SUPPLY_TIMEOUT = 1'b0,
	parameter longint unsigned FLAG_CYC = bms_pkg::FLAG_TIMEOUT_CYC,
	parameter longint unsigned SUPPLY_CYC = LONG_SUPPLY_TIMEOUT ?
		bms_pkg::SUPPLY_LONG_CYC : bms_pkg::SUPPLY_SHORT_CYC,
	parameter longint unsigned PULSE_CYC = bms_pkg::MANUAL_PULSE_CYC,
	parameter longint unsigned DEBOUNCE_CYC = bms_pkg::DEBOUNCE_CYC
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic low_threshold_input,
	input wire logic high_threshold_input,
	input wire logic supply_above_trip,
	input wire logic manual_reset_n,
	output logic low_battery_flag_n,
	output logic battery_weak_flag_n,
	output logic battery_empty_flag_n,
	output logic reset_n
);
	import bms_pkg::*;

	logic [SYNC_N-1:0] meta_r;
	logic [SYNC_N-1:0] sync_r;
	logic low_above;
	logic high_above;
	logic supply_ok;
	logic manual_high;
	logic empty_r;
	logic weak_r;
	logic single_r;
	logic supply_hold_r;
	logic pulse_r;
	bms_mr_e mr_state_r;
	bms_mr_e mr_state_nxt;
	logic mr_fire;

	bms_tmr_if empty_t ();
	bms_tmr_if weak_t ();
	bms_tmr_if single_t ();
	bms_tmr_if supply_t ();
	bms_tmr_if pulse_t ();
	bms_tmr_if deb_t ();

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++)
		begin : g_sync
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					meta_r[gi] <= SYNC_RST[gi];
					sync_r[gi] <= SYNC_RST[gi];
				end
				else
				begin
					meta_r[gi] <= gi == IDX_LOW ? low_threshold_input :
						gi == IDX_HIGH ? high_threshold_input :
						gi == IDX_SUPPLY ? supply_above_trip :
						manual_reset_n;
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	assign low_above = sync_r[IDX_LOW];
	assign high_above = sync_r[IDX_HIGH];
	assign supply_ok = sync_r[IDX_SUPPLY];
	// idle-high input: a held-high line never fires
	assign manual_high = sync_r[IDX_MANUAL];

	// flags start asserted: inputs read low until synchronised, so the
	// release timeout is always served after reset
	// empty flag assert
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			empty_r <= 1'b1;
		else if (!low_above)
			empty_r <= 1'b1;
		else if (empty_t.done)
			empty_r <= 1'b0;
	end
	assign empty_t.run = empty_r && low_above;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			weak_r <= 1'b1;
		else if (!high_above)
			weak_r <= 1'b1;
		else if (weak_t.done)
			weak_r <= 1'b0;
	end
	assign weak_t.run = weak_r && high_above && !empty_r;

	// single flag: low input sets, high input times release
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			single_r <= 1'b1;
		else if (!low_above)
			single_r <= 1'b1;
		else if (single_t.done)
			single_r <= 1'b0;
	end
	assign single_t.run = single_r && high_above;

	// unused variant's flag stays released
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			low_battery_flag_n <= FLAG_IDLE_N;
			battery_weak_flag_n <= FLAG_IDLE_N;
			battery_empty_flag_n <= FLAG_IDLE_N;
		end
		else
		begin
			low_battery_flag_n <= DUAL_OUTPUT ? FLAG_IDLE_N : !single_r;
			battery_weak_flag_n <= DUAL_OUTPUT ? !weak_r : FLAG_IDLE_N;
			battery_empty_flag_n <= DUAL_OUTPUT ? !empty_r : FLAG_IDLE_N;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			supply_hold_r <= 1'b1;
		else if (!supply_ok)
			supply_hold_r <= 1'b1;
		else if (supply_t.done)
			supply_hold_r <= 1'b0;
	end
	assign supply_t.run = supply_hold_r && supply_ok;

	// manual reset: fire on a low level only while armed, then hold
	// until the line has stayed high a whole debounce period
	always_comb
	begin
		mr_state_nxt = mr_state_r;
		mr_fire = 1'b0;
		case (mr_state_r)
			MR_ARMED:
			begin
				if (!manual_high)
				begin
					mr_fire = 1'b1;
					mr_state_nxt = MR_HELD;
				end
			end
			MR_HELD:
			begin
				if (deb_t.done)
					mr_state_nxt = MR_ARMED;
			end
			default:
				mr_state_nxt = MR_ARMED;
		endcase
	end
	assign deb_t.run = (mr_state_r == MR_HELD) && manual_high;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			mr_state_r <= MR_ARMED;
		else
			mr_state_r <= mr_state_nxt;
	end

	// fixed pulse, independent of how long the line stays low
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pulse_r <= 1'b0;
		else if (mr_fire)
			pulse_r <= 1'b1;
		else if (pulse_t.done)
			pulse_r <= 1'b0;
	end
	assign pulse_t.run = pulse_r;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			reset_n <= 1'b0;
		else
			reset_n <= !(supply_hold_r || pulse_r || mr_fire);
	end

	bms_timer #(.CYC(FLAG_CYC)) u_empty (.clk(clk), .sys_rst(sys_rst),
		.tif(empty_t));
	bms_timer #(.CYC(FLAG_CYC)) u_weak (.clk(clk), .sys_rst(sys_rst),
		.tif(weak_t));
	bms_timer #(.CYC(FLAG_CYC)) u_single (.clk(clk), .sys_rst(sys_rst),
		.tif(single_t));
	bms_timer #(.CYC(SUPPLY_CYC)) u_supply (.clk(clk), .sys_rst(sys_rst),
		.tif(supply_t));
	bms_timer #(.CYC(PULSE_CYC)) u_pulse (.clk(clk), .sys_rst(sys_rst),
		.tif(pulse_t));
	bms_timer #(.CYC(DEBOUNCE_CYC)) u_deb (.clk(clk), .sys_rst(sys_rst),
		.tif(deb_t));
endmodule

// file: tb/bms_top_assertions.sv
// port checks for bms_top
// assumes one clock, flags and reset active low
`timescale 1ns/10ps
module bms_top_assertions
#(
	parameter bit DUAL_OUTPUT = 1'b1,
	parameter longint unsigned FLAG_CYC = 20,
	parameter longint unsigned SUPPLY_CYC = 40
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic low_threshold_input,
	input wire logic high_threshold_input,
	input wire logic supply_above_trip,
	input wire logic manual_reset_n,
	input wire logic low_battery_flag_n,
	input wire logic battery_weak_flag_n,
	input wire logic battery_empty_flag_n,
	input wire logic reset_n
);
	logic [31:0] lc_r, hc_r, sc_r;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// cycles each input has stayed above trip
	always_ff @(posedge clk or posedge sys_rst)
	if (sys_rst)
	begin
		lc_r <= 32'h0000_0000;
		hc_r <= 32'h0000_0000;
		sc_r <= 32'h0000_0000;
	end
	else
	begin
		lc_r <= low_threshold_input ? lc_r + 1 : 32'h0000_0000;
		hc_r <= high_threshold_input ? hc_r + 1 : 32'h0000_0000;
		sc_r <= supply_above_trip ? sc_r + 1 : 32'h0000_0000;
	end
	empty_set_a: assert property
		(DUAL_OUTPUT && $fell(low_threshold_input) |->
		##[1:5] !battery_empty_flag_n)
		else $error("empty flag late");
	weak_set_a: assert property
		(DUAL_OUTPUT && $fell(high_threshold_input) |->
		##[1:5] !battery_weak_flag_n)
		else $error("weak flag late");
	single_set_a: assert property
		(!DUAL_OUTPUT && $fell(low_threshold_input) |->
		##[1:5] !low_battery_flag_n)
		else $error("single flag late");
	single_hold_a: assert property
		($rose(low_battery_flag_n) |-> hc_r >= FLAG_CYC)
		else $error("single flag released early");
	idle_flags_a: assert property
		(DUAL_OUTPUT ? low_battery_flag_n :
		battery_weak_flag_n && battery_empty_flag_n)
		else $error("other variant flag asserted");
	empty_hold_a: assert property
		($rose(battery_empty_flag_n) |-> lc_r >= FLAG_CYC)
		else $error("empty flag released early");
	empty_keep_a: assert property
		((DUAL_OUTPUT && !low_threshold_input) [*6] |->
		!battery_empty_flag_n)
		else $error("empty flag high while low");
	weak_order_a: assert property
		($rose(battery_weak_flag_n) |-> hc_r >= FLAG_CYC &&
		$past(battery_empty_flag_n, 16))
		else $error("weak flag released early");
	reset_fall_a: assert property
		($fell(supply_above_trip) |-> ##[1:5] !reset_n)
		else $error("reset late");
	reset_hold_a: assert property
		($rose(reset_n) |-> sc_r >= SUPPLY_CYC)
		else $error("reset released early");
	pulse_min_a: assert property
		($fell(reset_n) |-> !reset_n [*8])
		else $error("reset pulse short");
	cover property ($rose(battery_weak_flag_n));
	cover property ($fell(reset_n) && supply_above_trip);
	cover property ($rose(battery_empty_flag_n));
	cover property (!DUAL_OUTPUT && $rose(low_battery_flag_n));
endmodule
bind bms_top bms_top_assertions #(.DUAL_OUTPUT(DUAL_OUTPUT),
	.FLAG_CYC(FLAG_CYC),
	.SUPPLY_CYC(SUPPLY_CYC)) i_chk (.clk(clk), .sys_rst(sys_rst),
	.low_threshold_input(low_threshold_input),
	.high_threshold_input(high_threshold_input),
	.supply_above_trip(supply_above_trip),
	.manual_reset_n(manual_reset_n),
	.low_battery_flag_n(low_battery_flag_n),
	.battery_weak_flag_n(battery_weak_flag_n),
	.battery_empty_flag_n(battery_empty_flag_n), .reset_n(reset_n));

// file: tb/bms_host_model.sv
// pushbutton and host: press pulls the line low, host counts resets
// assumes press is a level from the bench
`timescale 1ns/10ps
module bms_host_model
(
	input wire logic reset_n,
	input wire logic press,
	output logic manual_reset_n,
	output int pulses
);
	initial pulses = 0;
	assign manual_reset_n = !press;
	always @(negedge reset_n)
		pulses++;
endmodule

// file: tb/tb_bms_top.sv
// bench for bms_top: integer run-length model checked every cycle
// assumes the hand-over latencies, short timeouts by parameter
`timescale 1ns/10ps
module tb_bms_top;
	localparam int F = 20;
	localparam int S = 40;
	localparam int P = 15;
	localparam int D = 10;
	logic clk, sys_rst, lo, hi, sup, press, mr_n, wk_n, em_n, rst_n;
	logic lb_n, sl_n, sw_n, se_n, srst_n;
	logic [2:0] lvl;
	bit ea, wa, wb, ra, rb;
	logic [31:0] seed;
	int n_errors, samples_checked, pulses, cyc, mh, mf, cnt;
	int r[3], z[3];
	bms_top #(.FLAG_CYC(F), .SUPPLY_CYC(S), .PULSE_CYC(P),
		.DEBOUNCE_CYC(D)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.low_threshold_input(lo), .high_threshold_input(hi),
		.supply_above_trip(sup), .manual_reset_n(mr_n),
		.low_battery_flag_n(lb_n), .battery_weak_flag_n(wk_n),
		.battery_empty_flag_n(em_n), .reset_n(rst_n));
	// single-output variant on the same inputs
	bms_top #(.DUAL_OUTPUT(1'b0), .FLAG_CYC(F), .SUPPLY_CYC(S),
		.PULSE_CYC(P), .DEBOUNCE_CYC(D)) i_dut_single (.clk(clk),
		.sys_rst(sys_rst), .low_threshold_input(lo),
		.high_threshold_input(hi), .supply_above_trip(sup),
		.manual_reset_n(mr_n), .low_battery_flag_n(sl_n),
		.battery_weak_flag_n(sw_n), .battery_empty_flag_n(se_n),
		.reset_n(srst_n));
	assign lvl = {sup, hi, lo};
	bms_host_model i_host (.reset_n(rst_n), .press(press),
		.manual_reset_n(mr_n), .pulses(pulses));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(input logic seen, input logic want);
		samples_checked++;
		if (seen !== want)
		begin
			n_errors++;
			$display("BAD %0t saw %b want %b", $time, seen, want);
		end
	endtask
	task automatic ex(input logic seen, input bit w0, input bit w1);
		if (w0)
			chk(seen, 1'b0);
		else if (w1)
			chk(seen, 1'b1);
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #4 clk = !clk;
	end
	// model: run lengths of each input as the design samples them
	always @(posedge clk)
	begin
		cyc++;
		mf++;
		// rearm wants the line high one cycle past the debounce count
		if (!mr_n && mh > D)
			mf = 0;
		mh = mr_n ? mh + 1 : 0;
		for (int i = 0; i < 3; i++)
		begin
			r[i] = lvl[i] ? r[i] + 1 : 0;
			z[i] = lvl[i] ? 0 : z[i] + 1;
			if (sys_rst)
				{r[i], z[i]} = 0;
		end
		if (sys_rst)
			{mh, mf} = {32'd1000, 32'd1000};
		// ceiling: about fourteen times the planned run
		if (cyc == 20000)
		begin
			n_errors++;
			test_done;
		end
	end
	always @(negedge clk)
	if (!sys_rst)
	begin
		ea = z[0] >= 5 || (r[0] >= 5 && r[0] <= F);
		wa = z[1] >= 5 || (r[1] >= 5 && (r[1] <= F ||
			(r[1] <= r[0] && r[0] <= 2 * F)));
		wb = r[1] >= F + 8 && r[0] >= 2 * F + 12;
		ra = z[2] >= 5 || (r[2] >= 5 && r[2] <= S) ||
			(mf >= 5 && mf <= P);
		rb = r[2] >= S + 8 && mf >= P + 8;
		ex(em_n, ea, r[0] >= F + 8);
		ex(wk_n, wa, wb);
		ex(rst_n, ra, rb);
		ex(srst_n, ra, rb);
		ex(sl_n, z[0] >= 5, r[0] >= F + 8 && r[1] >= F + 8);
		chk(lb_n && sw_n && se_n, 1'b1);
	end
	initial
	begin
		{sys_rst, lo, hi, sup, press} = 5'h1E;
		seed = 32'h0000_0016;
		step(3);
		sys_rst = 0;
		repeat (40)
		begin
			seed = xs(seed);
			{lo, hi, sup} = {|seed[1:0], |seed[3:2], |seed[6:4]};
			step(1 + seed[13:8]);
		end
		{lo, hi, sup} = 3'h0;
		step(8);
		{lo, hi, sup} = 3'h7;
		step(2 * F + 20);
		sup = 0;
		step(6);
		sup = 1;
		step(S / 2);
		sup = 0;
		step(2);
		sup = 1;
		step(S + 20);
		cnt = pulses;
		press = 1;
		step(30);
		repeat (8)
		begin
			seed = xs(seed);
			press = seed[0];
			step(1);
		end
		press = 0;
		step(3 * D);
		press = 1;
		step(2);
		press = 0;
		step(P + 20);
		chk(pulses == cnt + 2, 1'b1);
		test_done;
	end
endmodule
